//--- hw/vram_ctrl.sv
// module: ram-port cycle sequencer that drives a dual-port video dram
//
// What the datasheet requires
// [R1] hold strobe widths and precharge before next
// [R2] write enable high through read cycles
// [R3] wait full row access time before sampling
// [R4] output enable low at least access time
// [R5] early write: write enable before column; unmasked writes drop both on one edge
// [R6] output enable high around row fall
// [R7] write data valid before strobe falls; early write drives it on the column edge
// [R8] rmw: read under oe, write on we
// [R9] late write permitted by device
// [R10] page mode keeps row open, cycles column
// [R11] write enable low at row fall: mask
// [R12] mask zero blocks bit, one cycle
// [R13] device tristates when strobe/oe high
// [R14] device holds data until column rises
// [R15] refresh all 512 rows every 8 ms
// [R16] row-only refresh walks all row addresses
// [R17] column-before-row uses device counter
// [R18] hidden refresh: keep column low, cycle row
// [R19] transfer type chosen by pins at row fall
// [R20] transfer blocks independent port use
// [R21] transfers set serial direction and start
// [R22] row address picks transfer row
// [R23] column address gives serial start
// [R24] read transfer finishes on oe rise
// [R25] row then column over shared address
`timescale 1ns/100ps
`default_nettype none

module vram_ctrl
  import vram_ctrl_pkg::*;
#(
  parameter int REF_CYC = REF_INTERVAL_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request side
  input wire logic req_valid,
  input wire req_s req,
  output logic req_ready,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_valid,
  output logic serial_out_mode,
  // device pins
  output pins_s pins,
  output logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] mask_data_pins_in,
  output logic [DATA_W-1:0] mask_data_pins_out,
  output logic mask_data_pins_oe
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ROW = 4'h1,
    ST_COL = 4'h2,
    ST_ACCESS = 4'h3,
    ST_WRITE = 4'h4,
    ST_RMW_WR = 4'h5,
    ST_PAGE = 4'h6,
    ST_XFER = 4'h7,
    ST_CBR = 4'h8,
    ST_CBR_ROW = 4'h9,
    ST_PRE = 4'hA
  } state_e;

  state_e state_q;
  req_s cur_q;
  logic [7:0] tmr_q;
  logic [$clog2(REF_CYC+1)-1:0] ref_q;
  logic ref_due_q;
  logic [DATA_W-1:0] din_meta_q;
  logic [DATA_W-1:0] din_sync_q;

  // two-flop synchroniser on the shared data pins
  always_ff @(posedge clk) begin
    din_meta_q <= mask_data_pins_in;
    din_sync_q <= din_meta_q;
  end

  // refresh interval: one column-before-row refresh per slot
  always_ff @(posedge clk) begin
    if (rst) begin
      ref_q <= '0;
      ref_due_q <= 1'b0;
    end else if (ref_q == ($clog2(REF_CYC+1))'(REF_CYC - 1)) begin
      ref_q <= '0;
      ref_due_q <= 1'b1; // see [R15]
    end else begin
      ref_q <= ref_q + 1'b1;
      if (state_q == ST_CBR) begin
        ref_due_q <= 1'b0;
      end
    end
  end

  // cycle sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_PRE; // a reset mid-cycle still waits out precharge
      cur_q <= '0;
      tmr_q <= 8'(RP_CYC); // see [R1]
      pins <= '1;
      addr <= '0;
      mask_data_pins_out <= '0;
      mask_data_pins_oe <= 1'b0;
      rd_data <= '0;
      rd_valid <= 1'b0;
      req_ready <= 1'b0;
      serial_out_mode <= 1'b1;
    end else begin
      rd_valid <= 1'b0;
      req_ready <= 1'b0;
      if (tmr_q != TIMER_ZERO) begin
        tmr_q <= tmr_q - 1'b1;
      end
      case (state_q)
        ST_IDLE: begin
          if (ref_due_q) begin
            pins.column_strobe_n <= 1'b0; // see [R17]
            tmr_q <= 8'(CSR_CYC);
            state_q <= ST_CBR;
          end else if (req_valid) begin
            cur_q <= req;
            addr <= req.row; // see [R25]
            // modes selected by pin levels before row falls; see [R19]
            pins.transfer_output_enable_n <= !(req.cmd inside {CMD_READ_XFER, CMD_WRITE_XFER, CMD_PSEUDO_XFER});
            pins.mask_write_enable_n <= !(req.masked || req.cmd inside {CMD_WRITE_XFER, CMD_PSEUDO_XFER});
            pins.serial_enable_n <= (req.cmd != CMD_WRITE_XFER);
            mask_data_pins_out <= req.mask; // see [R11]
            mask_data_pins_oe <= req.masked && !(req.cmd inside {CMD_READ_XFER, CMD_WRITE_XFER, CMD_PSEUDO_XFER});
            req_ready <= 1'b1;
            tmr_q <= 8'(SETUP_CYC);
            state_q <= ST_ROW;
          end
        end
        ST_ROW: begin
          if (tmr_q == TIMER_ZERO) begin
            pins.row_strobe_n <= 1'b0; // see [R22]
            tmr_q <= 8'(RAS_CYC);
            state_q <= (cur_q.cmd == CMD_ROW_REFRESH) ? ST_PRE : ST_COL; // see [R16]
          end
        end
        ST_COL: begin
          // mask data only needs hold past row fall
          mask_data_pins_oe <= (cur_q.cmd == CMD_WRITE);
          mask_data_pins_out <= cur_q.wdata; // see [R7]
          addr <= cur_q.col; // see [R23]
          if (!(cur_q.cmd inside {CMD_READ_XFER, CMD_WRITE_XFER, CMD_PSEUDO_XFER})) begin
            pins.transfer_output_enable_n <= 1'b1; // see [R6]
            pins.mask_write_enable_n <= (cur_q.cmd != CMD_WRITE); // see [R2] [R5]
          end
          pins.column_strobe_n <= 1'b0;
          tmr_q <= 8'(ACC_CYC);
          case (cur_q.cmd)
            CMD_READ, CMD_RMW: state_q <= ST_ACCESS;
            CMD_WRITE: state_q <= ST_WRITE;
            default: state_q <= ST_XFER; // see [R20]
          endcase
        end
        ST_ACCESS: begin
          pins.transfer_output_enable_n <= 1'b0; // see [R4] [R8]
          if (tmr_q == TIMER_ZERO) begin
            rd_data <= din_sync_q; // see [R3]
            rd_valid <= 1'b1;
            if (cur_q.cmd == CMD_RMW) begin
              pins.transfer_output_enable_n <= 1'b1;
              mask_data_pins_out <= cur_q.wdata;
              tmr_q <= 8'(WP_CYC);
              state_q <= ST_RMW_WR;
            end else begin
              state_q <= ST_PAGE;
            end
          end
        end
        ST_RMW_WR: begin
          mask_data_pins_oe <= 1'b1;
          if (tmr_q == 8'(WP_CYC - 1)) begin
            pins.mask_write_enable_n <= 1'b0; // see [R8]
          end
          if (tmr_q == TIMER_ZERO) begin
            state_q <= ST_PAGE;
          end
        end
        ST_WRITE: begin
          if (tmr_q == TIMER_ZERO) begin
            state_q <= ST_PAGE;
          end
        end
        ST_PAGE: begin
          pins.column_strobe_n <= 1'b1;
          pins.transfer_output_enable_n <= 1'b1;
          pins.mask_write_enable_n <= 1'b1;
          mask_data_pins_oe <= 1'b0;
          // further column in same row keeps row strobe low; see [R10]
          if (req_valid && req.page && req.row == cur_q.row && req.cmd inside {CMD_READ, CMD_WRITE, CMD_RMW}) begin
            cur_q <= req;
            req_ready <= 1'b1;
            state_q <= ST_COL;
          end else begin
            tmr_q <= 8'(RP_CYC);
            pins.row_strobe_n <= 1'b1;
            state_q <= ST_PRE;
          end
        end
        ST_XFER: begin
          if (tmr_q == TIMER_ZERO) begin
            pins.transfer_output_enable_n <= 1'b1; // see [R24]
            pins.column_strobe_n <= 1'b1;
            serial_out_mode <= (cur_q.cmd == CMD_READ_XFER); // see [R21]
            tmr_q <= 8'(RP_CYC);
            pins.row_strobe_n <= 1'b1;
            state_q <= ST_PRE;
          end
        end
        ST_CBR: begin
          if (tmr_q == TIMER_ZERO) begin
            pins.row_strobe_n <= 1'b0; // see [R17] [R18]
            tmr_q <= 8'(RAS_CYC);
            state_q <= ST_CBR_ROW;
          end
        end
        ST_CBR_ROW: begin
          if (tmr_q == TIMER_ZERO) begin
            pins.row_strobe_n <= 1'b1;
            pins.column_strobe_n <= 1'b1;
            tmr_q <= 8'(RP_CYC);
            state_q <= ST_PRE;
          end
        end
        ST_PRE: begin
          // row-only refresh ends here after its row strobe width
          if (tmr_q == TIMER_ZERO) begin
            if (!pins.row_strobe_n) begin
              pins.row_strobe_n <= 1'b1;
              pins.transfer_output_enable_n <= 1'b1;
              pins.mask_write_enable_n <= 1'b1;
              mask_data_pins_oe <= 1'b0;
              tmr_q <= 8'(RP_CYC);
            end else begin
              pins.serial_enable_n <= 1'b1;
              state_q <= ST_IDLE; // see [R1]
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // row strobe low lasts at least its minimum width
  logic [7:0] ras_low_q;
  always_ff @(posedge clk) begin
    if (rst || pins.row_strobe_n) begin
      ras_low_q <= TIMER_ZERO;
    end else if (ras_low_q != 8'hFF) begin
      ras_low_q <= ras_low_q + 1'b1;
    end
  end

  sequence ras_rise_s;
    !$past(pins.row_strobe_n) && pins.row_strobe_n;
  endsequence

  ras_width_a: assert property (@(posedge clk) disable iff (rst) // see [R1]
    ras_rise_s |-> $past(ras_low_q) >= 8'(RAS_CYC))
    else $error("row strobe too short");

  precharge_a: assert property (@(posedge clk) disable iff (rst) // see [R1]
    ras_rise_s |-> pins.row_strobe_n [*4])
    else $error("row precharge violated");

  read_we_a: assert property (@(posedge clk) disable iff (rst) // see [R2]
    (state_q == ST_ACCESS && cur_q.cmd == CMD_READ) |-> pins.mask_write_enable_n)
    else $error("write enable low in read");

  early_oe_a: assert property (@(posedge clk) disable iff (rst) // see [R6]
    (state_q == ST_WRITE) |-> pins.transfer_output_enable_n)
    else $error("output enable low in early write");

  access_time_a: assert property (@(posedge clk) disable iff (rst) // see [R3]
    rd_valid |-> $past(!pins.column_strobe_n, 2))
    else $error("data sampled without column strobe");

  cbr_order_a: assert property (@(posedge clk) disable iff (rst) // see [R17]
    (state_q == ST_CBR && $past(state_q) == ST_IDLE) |-> !pins.column_strobe_n && pins.row_strobe_n)
    else $error("column not before row");

  xfer_oe_a: assert property (@(posedge clk) disable iff (rst) // see [R19]
    (state_q == ST_XFER) |-> !pins.transfer_output_enable_n && !pins.row_strobe_n)
    else $error("transfer without oe low");

  row_only_a: assert property (@(posedge clk) disable iff (rst) // see [R16]
    (state_q == ST_PRE && !pins.row_strobe_n) |-> pins.column_strobe_n && cur_q.cmd == CMD_ROW_REFRESH)
    else $error("column strobe low in row-only refresh");

  refresh_slot_a: assert property (@(posedge clk) disable iff (rst) // see [R15]
    $rose(ref_due_q) |-> ##[1:300] (state_q == ST_CBR))
    else $error("refresh not started");

endmodule

`default_nettype wire

//--- shared/vram_ctrl_pkg.sv
// package: timing constants, command codes and carrier structs for the video dram controller
package vram_ctrl_pkg;

  localparam int CLK_MHZ = 40;
  // timing figures in ns
  localparam int T_RAS_NS = 100;
  localparam int T_CAS_NS = 30;
  localparam int T_RP_NS = 90;
  localparam int T_ACC_NS = 120;
  localparam int ACCESS_FROM_OUTPUT_ENABLE_NS = 25;
  localparam int COLUMN_BEFORE_ROW_SETUP_NS = 10;
  localparam int T_WP_NS = 20;
  localparam int T_SETUP_NS = 25;
  // cycle counts, least times round up
  localparam int RAS_CYC = (T_RAS_NS * CLK_MHZ + 999) / 1000;
  localparam int CAS_CYC = (T_CAS_NS * CLK_MHZ + 999) / 1000;
  localparam int RP_CYC = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int OEA_CYC = (ACCESS_FROM_OUTPUT_ENABLE_NS * CLK_MHZ + 999) / 1000;
  localparam int CSR_CYC = (COLUMN_BEFORE_ROW_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  // refresh: 512 rows per 8 ms
  localparam int REF_ROWS = 512;
  localparam int REF_PERIOD_US = 8000;
  localparam int REF_INTERVAL_CYC = (REF_PERIOD_US * CLK_MHZ) / REF_ROWS;

  localparam int ADDR_W = 9;
  localparam int DATA_W = 4;
  localparam logic [7:0] TIMER_ZERO = 8'h00;

  typedef enum logic [2:0] {
    CMD_READ = 3'h0,
    CMD_WRITE = 3'h1,
    CMD_RMW = 3'h2,
    CMD_READ_XFER = 3'h3,
    CMD_WRITE_XFER = 3'h4,
    CMD_PSEUDO_XFER = 3'h5,
    CMD_ROW_REFRESH = 3'h6
  } cmd_e;

  typedef struct packed {
    cmd_e cmd;
    logic page;
    logic masked;
    logic [ADDR_W-1:0] row;
    logic [ADDR_W-1:0] col;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] mask;
  } req_s;

  // strobe pins, all active low
  typedef struct packed {
    logic row_strobe_n;
    logic column_strobe_n;
    logic transfer_output_enable_n;
    logic mask_write_enable_n;
    logic serial_enable_n;
  } pins_s;

endpackage

//--- sim/vram_ctrl_test.sv
// testbench for the video dram cycle sequencer
`timescale 1ns/100ps
`default_nettype none
module vram_ctrl_test;
  import vram_ctrl_pkg::*;
  typedef struct packed {req_s r; logic [DATA_W-1:0] exp;} case_s;
  logic clk = 1'h0, rst = 1'h1, req_valid = 1'h0, req_ready, rd_valid, serial_out_mode, drv_oe;
  req_s req = '0;
  pins_s pins;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] rd_data, drv_out, dev_out, dq;
  logic [ADDR_W-1:0] base;
  int fail_count = 0, total_checks = 0;
  case_s tbl [13];
  cmd_e xk [3] = '{CMD_READ_XFER, CMD_PSEUDO_XFER, CMD_WRITE_XFER};

  // clock and shared data pins
  always #12.5 clk = ~clk;
  assign dq = drv_oe ? drv_out : dev_out;

  vram_ctrl #(.REF_CYC(40)) vram_ctrl_i (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid), .serial_out_mode(serial_out_mode),
    .pins(pins), .addr(addr), .mask_data_pins_in(dq), .mask_data_pins_out(drv_out), .mask_data_pins_oe(drv_oe));
  vram_dev vram_dev_i (.pins(pins), .addr(addr), .dq_in(dq), .dq_out(dev_out), .dq_oe());

  // compare and count
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // hand one request over and, for reads, wait for the data
  task automatic issue(input req_s r, input logic [DATA_W-1:0] exp);
    int n;
    n = 0;
    req = r;
    req_valid = 1'h1;
    do begin
      @(posedge clk);
      #1;
    end while (req_ready !== 1'h1 && ++n < 400);
    req_valid = 1'h0;
    chk("req_ready", 1, req_ready);
    if (r.cmd inside {CMD_READ, CMD_RMW}) begin
      n = 0;
      while (rd_valid !== 1'h1 && n++ < 100) begin
        @(posedge clk);
        #1;
      end
      chk("rd_valid", 1, rd_valid);
      chk("rd_data", exp, rd_data);
    end else begin
      // let an edge pass so the next request is not raised in this step
      @(posedge clk);
      #1;
    end
  endtask

  function automatic case_s mk(input cmd_e c, input logic pg, input logic mw, input logic [ADDR_W-1:0] rw,
    input logic [ADDR_W-1:0] cl, input logic [DATA_W-1:0] wd, input logic [DATA_W-1:0] m, input logic [DATA_W-1:0] e);
    return '{'{c, pg, mw, rw, cl, wd, m}, e};
  endfunction

  // verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    tbl = '{mk(CMD_WRITE, 1'h0, 1'h0, 9'h005, 9'h003, 4'hA, 4'h0, 4'h0),
      mk(CMD_READ, 1'h0, 1'h0, 9'h005, 9'h003, 4'h0, 4'h0, 4'hA),
      mk(CMD_RMW, 1'h0, 1'h0, 9'h005, 9'h003, 4'h5, 4'h0, 4'hA),
      mk(CMD_READ, 1'h0, 1'h0, 9'h005, 9'h003, 4'h0, 4'h0, 4'h5),
      mk(CMD_WRITE, 1'h0, 1'h1, 9'h005, 9'h003, 4'hF, 4'h3, 4'h0),
      mk(CMD_READ, 1'h0, 1'h0, 9'h005, 9'h003, 4'h0, 4'h0, 4'h7),
      mk(CMD_WRITE, 1'h0, 1'h0, 9'h005, 9'h003, 4'h0, 4'h0, 4'h0),
      mk(CMD_READ, 1'h0, 1'h0, 9'h005, 9'h003, 4'h0, 4'h0, 4'h0),
      mk(CMD_WRITE, 1'h0, 1'h0, 9'h1FF, 9'h1FF, 4'h9, 4'h0, 4'h0),
      mk(CMD_READ, 1'h0, 1'h0, 9'h1FF, 9'h1FF, 4'h0, 4'h0, 4'h9),
      mk(CMD_READ, 1'h1, 1'h0, 9'h005, 9'h003, 4'h0, 4'h0, 4'h0),
      mk(CMD_WRITE, 1'h1, 1'h0, 9'h005, 9'h004, 4'hC, 4'h0, 4'h0),
      mk(CMD_READ, 1'h1, 1'h0, 9'h005, 9'h004, 4'h0, 4'h0, 4'hC)};
    repeat (6) @(posedge clk);
    #1;
    rst = 1'h0;
    foreach (tbl[i]) issue(tbl[i].r, tbl[i].exp);
    $display("test table done");
    base = vram_dev_i.ref_cnt;
    repeat (200) @(posedge clk);
    #1;
    chk("refresh", 1, (vram_dev_i.ref_cnt - base) >= 9'h004);
    issue('{CMD_ROW_REFRESH, 1'h0, 1'h0, 9'h0AB, 9'h000, 4'h0, 4'h0}, 4'h0);
    repeat (3) @(posedge clk);
    #1;
    chk("refresh_row", 9'h0AB, vram_dev_i.row);
    chk("refresh_col", 1, pins.column_strobe_n);
    $display("test refresh done");
    foreach (xk[i]) begin
      issue('{xk[i], 1'h0, 1'h0, 9'h012 + 9'(i), 9'h034, 4'h0, 4'h0}, 4'h0);
      issue(tbl[7].r, tbl[7].exp);
      chk("serial_mode", i == 0, serial_out_mode);
      chk("device_mode", i == 0, vram_dev_i.sout);
      chk("xfer_row", 9'h012 + 9'(i), vram_dev_i.xfer_row);
      chk("serial_start", 9'h034, vram_dev_i.ptr);
      chk("write_xfer", i == 2, vram_dev_i.wx);
    end
    $display("test transfers done");
    rst = 1'h1;
    @(posedge clk);
    #1;
    chk("pins_reset", 5'h1F, pins);
    chk("addr_reset", 0, addr);
    chk("oe_reset", 0, drv_oe);
    chk("mode_reset", 1, serial_out_mode);
    rst = 1'h0;
    issue(tbl[7].r, tbl[7].exp);
    $display("test reset done");
    results();
  end

  // watchdog against a hang
  initial begin
    #(25 * 5000);
    fail_count++;
    $display("[FAIL] watchdog expected done seen hang");
    results();
  end
endmodule
`default_nettype wire

//--- sim/vram_dev.sv
// behavioural model of the video dram ram port
`timescale 1ns/100ps
`default_nettype none
module vram_dev
  import vram_ctrl_pkg::*;
(
  // strobes and address
  input wire pins_s pins,
  input wire logic [ADDR_W-1:0] addr,
  // shared data pins
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe
);
  logic [DATA_W-1:0] mem [2**(2*ADDR_W)];
  logic [ADDR_W-1:0] row = '0, col = '0, xfer_row = '0, ptr = '0, ref_cnt = '0;
  logic [DATA_W-1:0] wmask = '1, last = '0;
  logic xfer = 1'h0, pend = 1'h0, sout = 1'h1, wx = 1'h0;

  // masked merge of the word on the data pins
  task automatic put();
    mem[{row, col}] = (mem[{row, col}] & ~wmask) | (dq_in & wmask);
  endtask

  // cycle kind is fixed by the pins at row strobe fall
  always @(negedge pins.row_strobe_n) begin
    xfer = 1'h0;
    wmask = '1;
    if (!pins.column_strobe_n) begin
      ref_cnt = ref_cnt + 1'h1;
    end else begin
      row = addr;
      xfer = !pins.transfer_output_enable_n;
      if (xfer) begin
        xfer_row = addr;
        pend = pins.mask_write_enable_n;
        wx = !pins.mask_write_enable_n && !pins.serial_enable_n;
      end else if (!pins.mask_write_enable_n) begin
        wmask = dq_in;
      end
    end
  end

  // column latch, serial start and early write
  always @(negedge pins.column_strobe_n) begin
    if (!pins.row_strobe_n) begin
      col = addr;
      if (xfer) ptr = addr;
      else if (!pins.mask_write_enable_n) begin
        #1; // take data inside its hold window, clear of the strobe edge
        put();
      end
    end
  end

  // late and read-modify-write data taken on the write enable edge
  always @(negedge pins.mask_write_enable_n) begin
    if (!pins.row_strobe_n && !pins.column_strobe_n && !xfer) put();
  end

  // a transfer completes when output enable rises
  always @(posedge pins.transfer_output_enable_n) begin
    if (xfer) sout = pend;
  end

  // read data only while column strobe and output enable are low
  always @(pins or row or col or xfer) begin
    dq_oe = !pins.column_strobe_n && !pins.transfer_output_enable_n && !xfer && pins.mask_write_enable_n;
    if (dq_oe) last = mem[{row, col}];
    dq_out = dq_oe ? last : ~last; // released lines show no stale value
  end
endmodule
`default_nettype wire
